// file: core/ibe_core.v
// Functional notes
// RULE_01: 8-bit transmit byte; write starts transfer
// RULE_02: write clears transmitter-empty until byte shifted
// RULE_03: new transaction: start, then address byte
// RULE_04: byte sent sets transmitter-empty, raises interrupt
// RULE_05: stop-after-write 0 keeps bus held
// RULE_06: stop-after-write 1 issues stop after byte
// RULE_07: open transaction: later write sends byte only
// RULE_08: read direction: write launches read, data unused
// RULE_09: read launch clears receiver-full first
// RULE_10: received byte sets receiver-full, raises interrupt
// RULE_11: reading receive byte clears receiver-full
// RULE_12: stop-after-read 1 stops after latching byte
// RULE_13: stop-after-read 0 keeps read open
// RULE_14: software reads each byte, sets stop before last
// RULE_15: software sets word address by dummy write
// RULE_16: software loads write address before first byte
// RULE_17: single write: stop enabled for data byte
// RULE_18: page write: stop only on final byte
// RULE_19: status bit layout with transmitter-empty reset 1
// RULE_20: address bits 7..1, direction bit 0
// RULE_21: no-ack sets error; write one clears
// RULE_22: check target ack; no-ack last read byte
// RULE_23: each interrupt gated by its enable bit
// RULE_24: serial clock from system clock, idle high
`timescale 1ns/1ns
`include "ibe_defs.vh"

module ibe_core #(
    parameter ADDR_W = 8
) (
    // clock, reset, enable
    input wire core_clk,
    input wire reset,
    input wire ce,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // serial clock pin
    input wire sclIn,
    output reg sclOut,
    output reg sclOe,
    // serial data pin
    input wire sdaIn,
    output reg sdaOut,
    output reg sdaOe,
    // interrupt requests
    output reg txIrq,
    output reg rxIrq
);

    localparam [5:0] S_IDLE = 6'h01;
    localparam [5:0] S_START = 6'h02;
    localparam [5:0] S_SHIFT = 6'h04;
    localparam [5:0] S_STOP = 6'h08;
    localparam [5:0] S_HOLD = 6'h10;
    localparam [5:0] S_RXWAIT = 6'h20;

    localparam [7:0] STAT_RST = `IBE_STATUS_RST;

    localparam [2:0] SEL_NONE = 3'h0;
    localparam [2:0] SEL_STATUS = 3'h1;
    localparam [2:0] SEL_ADDR = 3'h2;
    localparam [2:0] SEL_RXD = 3'h3;
    localparam [2:0] SEL_TXD = 3'h4;

    // register select from bus address
    function [2:0] regSel;
        input [ADDR_W-1:0] a;
        begin
            case (a[7:0])
                `IBE_OFF_STATUS: regSel = SEL_STATUS;
                `IBE_OFF_ADDR: regSel = SEL_ADDR;
                `IBE_OFF_RXD: regSel = SEL_RXD;
                `IBE_OFF_TXD: regSel = SEL_TXD;
                default: regSel = SEL_NONE;
            endcase
        end
    endfunction

    // status/control bits
    reg stopWrite;
    reg stopRead;
    reg txIrqEn;
    reg txEmpty;
    reg fastSpeed;
    reg busError;
    reg rxIrqEn;
    reg rxFull;
    // data registers
    reg [7:0] targetAddress;
    reg [7:0] receiveByte;
    reg [7:0] transmitByte;
    // engine state
    reg [5:0] state;
    reg [1:0] quarter;
    reg [3:0] bitCnt;
    reg [7:0] shiftReg;
    reg addrPhase;
    reg rxMode;
    reg readTxn;
    reg ackBit;
    reg launchPend;
    reg sclLow;
    reg sdaLow;
    // pin synchronisers
    reg sclMeta;
    reg sclSync;
    reg sdaMeta;
    reg sdaSync;

    wire tick;
    wire setupPhase;
    wire accessDone;
    wire wrDone;
    wire rdDone;
    wire [2:0] accSel;
    wire [2:0] setupSel;
    wire [7:0] statusWord;
    wire advance;

    assign setupPhase = psel & ~penable;
    assign accessDone = psel & penable & pready;
    assign wrDone = accessDone & pwrite;
    assign rdDone = accessDone & ~pwrite;
    assign accSel = regSel(paddr);
    assign setupSel = regSel(paddr);

    // status layout
    assign statusWord = {rxFull, rxIrqEn, busError, fastSpeed, // RULE_19
                         txEmpty, txIrqEn, stopRead, stopWrite};

    // quarter step, held while a target stretches the clock
    assign advance = tick & ~(quarter == 2'h2 & ~sclSync &
        (state == S_START | state == S_SHIFT | state == S_STOP));

    ibe_tick u_tick (
        .core_clk(core_clk),
        .reset(reset),
        .ce(ce),
        .fast(fastSpeed),
        .tick(tick)
    );

    // two-stage pin sampling
    always @(posedge core_clk) begin
        if (reset) begin
            sclMeta <= 1'b1;
            sclSync <= 1'b1;
            sdaMeta <= 1'b1;
            sdaSync <= 1'b1;
        end else if (ce) begin
            sclMeta <= sclIn;
            sclSync <= sclMeta;
            sdaMeta <= sdaIn;
            sdaSync <= sdaMeta;
        end
    end

    // bus answer, one wait-free access phase
    always @(posedge core_clk) begin
        if (reset) begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else if (ce) begin
            pready <= setupPhase;
            pslverr <= setupPhase & (setupSel == SEL_NONE);
            if (setupPhase & ~pwrite) begin
                case (setupSel)
                    SEL_STATUS: prdata <= {24'h000000, statusWord};
                    SEL_ADDR: prdata <= {24'h000000, targetAddress};
                    SEL_RXD: prdata <= {24'h000000, receiveByte};
                    SEL_TXD: prdata <= {24'h000000, transmitByte};
                    default: prdata <= 32'h00000000;
                endcase
            end else if (setupPhase) begin
                prdata <= 32'h00000000;
            end
        end
    end

    // pins and interrupt requests
    always @(posedge core_clk) begin
        if (reset) begin
            sclOut <= 1'b0;
            sclOe <= 1'b0;
            sdaOut <= 1'b0;
            sdaOe <= 1'b0;
            txIrq <= 1'b0;
            rxIrq <= 1'b0;
        end else if (ce) begin
            sclOut <= 1'b0;
            sclOe <= sclLow; // RULE_24
            sdaOut <= 1'b0;
            sdaOe <= sdaLow;
            txIrq <= txEmpty & txIrqEn; // RULE_23
            rxIrq <= rxFull & rxIrqEn; // RULE_23
        end
    end

    // registers and byte engine
    always @(posedge core_clk) begin
        if (reset) begin
            stopWrite <= STAT_RST[`IBE_STAT_SWR];
            stopRead <= STAT_RST[`IBE_STAT_SRD];
            txIrqEn <= STAT_RST[`IBE_STAT_TIE];
            txEmpty <= STAT_RST[`IBE_STAT_TXE];
            fastSpeed <= STAT_RST[`IBE_STAT_SPD];
            busError <= STAT_RST[`IBE_STAT_ERR];
            rxIrqEn <= STAT_RST[`IBE_STAT_RIE];
            rxFull <= STAT_RST[`IBE_STAT_RXF];
            targetAddress <= `IBE_ADDR_RST;
            receiveByte <= `IBE_RXD_RST;
            transmitByte <= `IBE_TXD_RST;
            state <= S_IDLE;
            quarter <= 2'h0;
            bitCnt <= 4'h0;
            shiftReg <= 8'h00;
            addrPhase <= 1'b0;
            rxMode <= 1'b0;
            readTxn <= 1'b0;
            ackBit <= 1'b1;
            launchPend <= 1'b0;
            sclLow <= 1'b0;
            sdaLow <= 1'b0;
        end else if (ce) begin
            // software side: clears first, hardware sets below win
            if (wrDone & accSel == SEL_STATUS) begin
                stopWrite <= pwdata[`IBE_STAT_SWR];
                stopRead <= pwdata[`IBE_STAT_SRD];
                txIrqEn <= pwdata[`IBE_STAT_TIE];
                fastSpeed <= pwdata[`IBE_STAT_SPD];
                rxIrqEn <= pwdata[`IBE_STAT_RIE];
                if (pwdata[`IBE_STAT_ERR])
                    busError <= 1'b0; // RULE_21
            end
            if (wrDone & accSel == SEL_ADDR)
                targetAddress <= pwdata[7:0]; // RULE_20
            if (wrDone & accSel == SEL_TXD) begin
                transmitByte <= pwdata[7:0]; // RULE_01
                txEmpty <= 1'b0; // RULE_02
                launchPend <= 1'b1; // RULE_01
            end
            if (rdDone & accSel == SEL_RXD)
                rxFull <= 1'b0; // RULE_11

            if (advance)
                quarter <= quarter + 2'h1;

            case (state)
                S_IDLE: begin
                    sclLow <= 1'b0; // RULE_24
                    sdaLow <= 1'b0;
                    if (launchPend) begin
                        launchPend <= 1'b0;
                        readTxn <= targetAddress[`IBE_ADDR_DIR];
                        if (targetAddress[`IBE_ADDR_DIR])
                            rxFull <= 1'b0; // RULE_09
                        shiftReg <= targetAddress; // RULE_03
                        addrPhase <= 1'b1;
                        rxMode <= 1'b0;
                        quarter <= 2'h0;
                        state <= S_START; // RULE_03
                    end
                end
                S_HOLD: begin
                    if (launchPend) begin
                        launchPend <= 1'b0;
                        readTxn <= targetAddress[`IBE_ADDR_DIR];
                        quarter <= 2'h0;
                        bitCnt <= 4'h0;
                        rxMode <= 1'b0;
                        if (targetAddress[`IBE_ADDR_DIR]) begin
                            rxFull <= 1'b0; // RULE_09
                            shiftReg <= targetAddress; // RULE_08
                            addrPhase <= 1'b1;
                            state <= S_START;
                        end else begin
                            shiftReg <= transmitByte; // RULE_07
                            addrPhase <= 1'b0;
                            state <= S_SHIFT; // RULE_07
                        end
                    end
                end
                S_RXWAIT: begin
                    if (~rxFull) begin // RULE_13
                        quarter <= 2'h0;
                        bitCnt <= 4'h0;
                        state <= S_SHIFT;
                    end
                end
                S_START: begin
                    if (advance) begin
                        case (quarter)
                            2'h0: sdaLow <= 1'b0;
                            2'h1: sclLow <= 1'b0;
                            2'h2: sdaLow <= 1'b1; // RULE_03
                            default: begin
                                sclLow <= 1'b1;
                                bitCnt <= 4'h0;
                                state <= S_SHIFT;
                            end
                        endcase
                    end
                end
                S_SHIFT: begin
                    if (advance) begin
                        case (quarter)
                            2'h0: begin
                                if (bitCnt == 4'h8)
                                    sdaLow <= rxMode & ~stopRead; // RULE_22
                                else
                                    sdaLow <= ~rxMode & ~shiftReg[7];
                            end
                            2'h1: sclLow <= 1'b0;
                            2'h2: begin
                                if (bitCnt == 4'h8)
                                    ackBit <= sdaSync; // RULE_22
                                else
                                    shiftReg <= {shiftReg[6:0], sdaSync};
                            end
                            default: begin
                                sclLow <= 1'b1;
                                if (bitCnt != 4'h8) begin
                                    bitCnt <= bitCnt + 4'h1;
                                end else if (addrPhase) begin
                                    addrPhase <= 1'b0;
                                    bitCnt <= 4'h0;
                                    if (ackBit) begin
                                        busError <= 1'b1; // RULE_21
                                        txEmpty <= 1'b1;
                                        state <= S_STOP;
                                    end else if (readTxn) begin
                                        txEmpty <= 1'b1; // RULE_08
                                        rxMode <= 1'b1;
                                    end else begin
                                        shiftReg <= transmitByte;
                                    end
                                end else if (~rxMode) begin
                                    txEmpty <= 1'b1; // RULE_04
                                    if (ackBit) begin
                                        busError <= 1'b1; // RULE_21
                                        state <= S_STOP;
                                    end else if (stopWrite) begin
                                        state <= S_STOP; // RULE_06
                                    end else begin
                                        state <= S_HOLD; // RULE_05
                                    end
                                end else begin
                                    receiveByte <= shiftReg; // RULE_10
                                    rxFull <= 1'b1; // RULE_10
                                    if (stopRead)
                                        state <= S_STOP; // RULE_12
                                    else
                                        state <= S_RXWAIT; // RULE_13
                                end
                            end
                        endcase
                    end
                end
                S_STOP: begin
                    if (advance) begin
                        case (quarter)
                            2'h0: sdaLow <= 1'b1;
                            2'h1: sclLow <= 1'b0;
                            2'h2: sdaLow <= 1'b1;
                            default: begin
                                sdaLow <= 1'b0; // RULE_06
                                rxMode <= 1'b0;
                                state <= S_IDLE;
                            end
                        endcase
                    end
                end
                default: begin
                    sclLow <= 1'b0;
                    sdaLow <= 1'b0;
                    state <= S_IDLE;
                end
            endcase
        end
    end

endmodule

// file: core/ibe_tick.v
`timescale 1ns/1ns
`include "ibe_defs.vh"

module ibe_tick #(
    parameter STD_CNT = `IBE_STD_QUARTER_CYC,
    parameter FAST_CNT = `IBE_FAST_QUARTER_CYC
) (
    // clock and control
    input wire core_clk,
    input wire reset,
    input wire ce,
    // rate select
    input wire fast,
    // quarter-period strobe
    output reg tick
);

    localparam integer STD_M1 = STD_CNT - 1;
    localparam integer FAST_M1 = FAST_CNT - 1;
    localparam [7:0] STD_LOAD = STD_M1[7:0];
    localparam [7:0] FAST_LOAD = FAST_M1[7:0];

    reg [7:0] count;

    // quarter ticks at standard or fast rate
    always @(posedge core_clk) begin // RULE_24
        if (reset) begin
            count <= 8'h00;
            tick <= 1'b0;
        end else if (ce) begin
            if (count == 8'h00) begin
                count <= fast ? FAST_LOAD : STD_LOAD;
                tick <= 1'b1;
            end else begin
                count <= count - 8'h01;
                tick <= 1'b0;
            end
        end
    end

endmodule

// file: pkg/ibe_defs.vh
`ifndef IBE_DEFS_VH
`define IBE_DEFS_VH

// register byte offsets on the bus
`define IBE_OFF_STATUS 8'h00
`define IBE_OFF_ADDR 8'h04
`define IBE_OFF_RXD 8'h08
`define IBE_OFF_TXD 8'h0C

// status/control field positions
`define IBE_STAT_SWR 0
`define IBE_STAT_SRD 1
`define IBE_STAT_TIE 2
`define IBE_STAT_TXE 3
`define IBE_STAT_SPD 4
`define IBE_STAT_ERR 5
`define IBE_STAT_RIE 6
`define IBE_STAT_RXF 7

// target address field positions
`define IBE_ADDR_DIR 0

// reset values
`define IBE_STATUS_RST 8'h08
`define IBE_ADDR_RST 8'h00
`define IBE_RXD_RST 8'h00
`define IBE_TXD_RST 8'h00

// timing: quarter of a serial clock period
`define IBE_CLK_NS 20
`define IBE_STD_QUARTER_NS 2500
`define IBE_FAST_QUARTER_NS 625
`define IBE_STD_QUARTER_CYC \
    ((`IBE_STD_QUARTER_NS + `IBE_CLK_NS - 1) / `IBE_CLK_NS)
`define IBE_FAST_QUARTER_CYC \
    ((`IBE_FAST_QUARTER_NS + `IBE_CLK_NS - 1) / `IBE_CLK_NS)

`endif

// file: verif/i2c_master_byte_engine_tb.sv
`timescale 1ns/1ns
module i2c_master_byte_engine_tb;
    localparam [6:0] TADDR = 7'h50;
    reg core_clk = 1'h0;
    reg reset = 1'h1;
    reg psel = 1'h0;
    reg penable = 1'h0;
    reg pwrite = 1'h0;
    reg [7:0] paddr = 8'h00;
    reg [31:0] pwdata = 32'h0;
    reg nack = 1'h0;
    reg slow = 1'h0;
    reg [31:0] rdat;
    integer err_total = 0;
    integer checked = 0;
    wire [31:0] prdata;
    wire pready, pslverr, sclOut, sclOe, sdaOut, sdaOe, txIrq, rxIrq;
    wire tSda, tScl, go;
    wire [7:0] lastByte, nStarts, nStops, nBytes;
    wire scl = !(sclOe | tScl);
    wire sda = !(sdaOe | tSda);
    ibe_core dut (.core_clk(core_clk), .reset(reset), .ce(1'h1),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sclIn(scl), .sclOut(sclOut), .sclOe(sclOe),
        .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe), .txIrq(txIrq),
        .rxIrq(rxIrq));
    ibe_target #(.ADDR(TADDR)) tgt (.scl(scl), .sda(sda), .nack(nack),
        .slow(slow), .rdBase(8'hA5), .sdaOe(tSda), .sclOe(tScl), .go(go),
        .lastByte(lastByte), .nStarts(nStarts), .nStops(nStops),
        .nBytes(nBytes));
    initial forever #10 core_clk = ~core_clk;
    task conclude;
        begin
            $display("checks %0d mismatches %0d", checked, err_total);
            if (err_total == 0 && checked > 0) $display("ALL TESTS PASSED");
            else $display("TESTS FAILED");
            $finish;
        end
    endtask
    task chk(input [8*8:1] nm, input [31:0] exp, input [31:0] got);
        begin
            checked = checked + 1;
            if (got !== exp) begin
                err_total = err_total + 1;
                $display("mismatch %0s expected %h seen %h", nm, exp, got);
            end
        end
    endtask
    task apb(input w, input [7:0] a, input [31:0] d);
        integer n;
        begin
            @(posedge core_clk);
            psel <= 1'h1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge core_clk);
            penable <= 1'h1;
            n = 0;
            do begin
                @(posedge core_clk);
                n = n + 1;
            end while (pready !== 1'h1 && n < 50);
            rdat = prdata;
            psel <= 1'h0;
            penable <= 1'h0;
            if (n == 50) chk("pready", 32'h1, 32'h0);
        end
    endtask
    task wr(input [7:0] a, input [7:0] d);
        apb(1'h1, a, {24'h0, d});
    endtask
    task rdc(input [7:0] a, input [7:0] exp);
        begin
            apb(1'h0, a, 32'h0);
            chk("reg", {24'h0, exp}, rdat);
        end
    endtask
    task waitBit(input [2:0] b, input v);
        integer i;
        begin
            i = 0;
            apb(1'h0, 8'h00, 32'h0);
            while (rdat[b] !== v && i < 5000) begin
                apb(1'h0, 8'h00, 32'h0);
                i = i + 1;
            end
            chk("flag", {31'h0, v}, {31'h0, rdat[b]});
        end
    endtask
    task waitCnt(input sel, input [7:0] n);
        integer i;
        begin
            i = 0;
            while ((sel ? nStarts : nStops) !== n && i < 3000) begin
                @(posedge core_clk);
                i = i + 1;
            end
            chk("count", {24'h0, n}, {24'h0, sel ? nStarts : nStops});
        end
    endtask
    task t_reset;
        begin
            rdc(8'h00, 8'h08);
            rdc(8'h04, 8'h00);
            rdc(8'h08, 8'h00);
            rdc(8'h0C, 8'h00);
            apb(1'h0, 8'h10, 32'h0);
            chk("pslverr", 32'h1, {31'h0, pslverr});
            wr(8'h00, 8'h17);
            rdc(8'h00, 8'h1F);
            chk("txIrq", 32'h1, {31'h0, txIrq});
            wr(8'h00, 8'h13);
            rdc(8'h00, 8'h1B);
            chk("txIrq", 32'h0, {31'h0, txIrq});
            wr(8'h04, 8'hA1);
            rdc(8'h04, 8'hA1);
            $display("test reset done");
        end
    endtask
    task t_write;
        begin
            wr(8'h00, 8'h10);
            wr(8'h04, {TADDR, 1'h0});
            wr(8'h0C, 8'h12);
            rdc(8'h00, 8'h10);
            rdc(8'h0C, 8'h12);
            waitBit(3'h3, 1'h1);
            chk("starts", 32'h1, {24'h0, nStarts});
            chk("bytes", 32'h2, {24'h0, nBytes});
            repeat (300) @(posedge core_clk);
            chk("stops", 32'h0, {24'h0, nStops});
            wr(8'h0C, 8'h34);
            waitBit(3'h3, 1'h1);
            wr(8'h00, 8'h11);
            wr(8'h0C, 8'h56);
            waitBit(3'h3, 1'h1);
            waitCnt(1'h0, 8'h01);
            chk("starts", 32'h1, {24'h0, nStarts});
            chk("bytes", 32'h4, {24'h0, nBytes});
            chk("last", 32'h56, {24'h0, lastByte});
            rdc(8'h00, 8'h19);
            $display("test write done");
        end
    endtask
    task t_read;
        begin
            slow = 1'h1;
            wr(8'h00, 8'h50);
            wr(8'h04, {TADDR, 1'h1});
            wr(8'h0C, 8'hEE);
            waitBit(3'h7, 1'h1);
            chk("rxIrq", 32'h1, {31'h0, rxIrq});
            chk("bytes", 32'h5, {24'h0, nBytes});
            rdc(8'h08, 8'hA5);
            rdc(8'h00, 8'h58);
            waitBit(3'h7, 1'h1);
            chk("stops", 32'h1, {24'h0, nStops});
            wr(8'h00, 8'h52);
            rdc(8'h08, 8'hA6);
            waitBit(3'h7, 1'h1);
            waitCnt(1'h0, 8'h02);
            chk("mack", 32'h0, {31'h0, go});
            wr(8'h0C, 8'h00);
            waitCnt(1'h1, 8'h03);
            rdc(8'h00, 8'h52);
            waitBit(3'h7, 1'h1);
            rdc(8'h08, 8'hA5);
            waitCnt(1'h0, 8'h03);
            slow = 1'h0;
            $display("test read done");
        end
    endtask
    task t_nack;
        begin
            nack = 1'h1;
            wr(8'h00, 8'h15);
            wr(8'h04, {TADDR, 1'h0});
            wr(8'h0C, 8'h77);
            waitBit(3'h3, 1'h1);
            rdc(8'h00, 8'h3D);
            waitCnt(1'h0, 8'h04);
            wr(8'h00, 8'h15);
            rdc(8'h00, 8'h3D);
            wr(8'h00, 8'h35);
            rdc(8'h00, 8'h1D);
            chk("txIrq", 32'h1, {31'h0, txIrq});
            chk("bytes", 32'h7, {24'h0, nBytes});
            nack = 1'h0;
            $display("test nack done");
        end
    endtask
    initial begin
        repeat (10) @(posedge core_clk);
        reset <= 1'h0;
        t_reset;
        t_write;
        t_read;
        t_nack;
        conclude;
    end
    initial begin
        #1500000;
        err_total = err_total + 1;
        conclude;
    end
endmodule

// file: verif/ibe_checker.sv
`timescale 1ns/1ns
module ibe_checker #(
    parameter ADDR_W = 8
) (
    // clock and reset
    input wire core_clk,
    input wire reset,
    // apb
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [ADDR_W-1:0] paddr,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    // pins and interrupts
    input wire sclOut,
    input wire sclOe,
    input wire sdaOut,
    input wire sdaOe,
    input wire txIrq,
    input wire rxIrq
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);
    wire acc = psel && penable && pready;
    wire wrTx = acc && pwrite && paddr[7:0] == 8'h0C;
    wire rdRx = acc && !pwrite && paddr[7:0] == 8'h08;
    property p_answer;
        psel && !penable |=> pready;
    endproperty
    a_answer: assert property (p_answer) else $error("no pready");
    property p_once;
        pready |=> !pready;
    endproperty
    a_once: assert property (p_once) else $error("pready held");
    property p_unmapped;
        acc |-> pslverr == (paddr[7:0] > 8'h0C);
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("bad pslverr");
    property p_narrow;
        acc && !pwrite |-> prdata[31:8] == 24'h0;
    endproperty
    a_narrow: assert property (p_narrow) else $error("wide read");
    property p_txBusy;
        wrTx |-> ##[1:2] !txIrq;
    endproperty
    a_txBusy: assert property (p_txBusy) else $error("tx irq stays");
    property p_rxClear;
        rdRx |-> ##[1:2] !rxIrq;
    endproperty
    a_rxClear: assert property (p_rxClear) else $error("rx irq stays");
    property p_start;
        wrTx && !sclOe && !sdaOe |-> ##[1:1000] (sdaOe && !sclOe);
    endproperty
    a_start: assert property (p_start) else $error("no start");
    property p_idle;
        $fell(reset) |-> !sclOe && !sdaOe;
    endproperty
    a_idle: assert property (p_idle) else $error("bus not idle");
    property p_drain;
        !sclOut && !sdaOut;
    endproperty
    a_drain: assert property (p_drain) else $error("pin driven high");
    c_tx: cover property (wrTx);
    c_rx: cover property (rdRx);
    c_err: cover property (acc && pslverr);
endmodule
bind ibe_core ibe_checker #(.ADDR_W(ADDR_W)) u_chk (.core_clk(core_clk),
    .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sclOut(sclOut), .sclOe(sclOe), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .txIrq(txIrq), .rxIrq(rxIrq));

// file: verif/ibe_target.sv
`timescale 1ns/1ns
module ibe_target #(
    parameter [6:0] ADDR = 7'h50
) (
    // bus lines and controls
    input wire scl,
    input wire sda,
    input wire nack,
    input wire slow,
    input wire [7:0] rdBase,
    // pin pulls and monitors
    output reg sdaOe,
    output reg sclOe,
    output reg go,
    output reg [7:0] lastByte,
    output reg [7:0] nStarts,
    output reg [7:0] nStops,
    output reg [7:0] nBytes
);
    reg [7:0] sh = 8'h00;
    reg [7:0] rd = 8'h00;
    reg [3:0] bitCnt = 4'h0;
    reg act = 1'h0;
    reg first = 1'h0;
    reg reading = 1'h0;
    initial begin
        {sdaOe, sclOe, go} = 3'h0;
        {lastByte, nStarts, nStops, nBytes} = 32'h0;
    end
    always @(negedge sda) if (scl === 1'h1) begin
        {act, first, reading, bitCnt} = 7'h60;
        rd = rdBase;
        nStarts = nStarts + 8'h01;
    end
    always @(posedge sda) if (scl === 1'h1 && act) begin
        act = 1'h0;
        sdaOe = 1'h0;
        nStops = nStops + 8'h01;
    end
    always @(posedge scl) if (act) begin
        if (bitCnt < 4'h8) sh = {sh[6:0], sda};
        if (bitCnt == 4'h8) go = !sda;
        bitCnt = bitCnt + 4'h1;
    end
    always @(negedge scl) if (act) begin
        if (bitCnt == 4'h8 && !reading) begin
            lastByte = sh;
            nBytes = nBytes + 8'h01;
            if (first) reading = sh[7:1] == ADDR && sh[0];
            sdaOe = !nack && (!first || sh[7:1] == ADDR);
            first = 1'h0;
        end else if (bitCnt == 4'h8) begin
            sdaOe = 1'h0;
            rd = rd + 8'h01;
        end else if (bitCnt == 4'h9) begin
            bitCnt = 4'h0;
            reading = reading && go;
            sdaOe = reading && !rd[7];
        end else if (reading) sdaOe = !rd[4'h7 - bitCnt];
        if (slow) begin
            sclOe = 1'h1;
            #2000;
            sclOe = 1'h0;
        end
    end
endmodule
